// ==== rtl/udgc_pkg.sv ====
package udgc_pkg;

  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CYCLES_PER_US = CLK_HZ / 1_000_000;
  localparam int DISCHARGE_US = 100;
  localparam int HNP_WAIT_US = 3000;
  localparam int SUSPEND_IDLE_US = 3000;
  localparam int DISCHARGE_CYCLES = DISCHARGE_US * CYCLES_PER_US;
  localparam int HNP_WAIT_CYCLES = HNP_WAIT_US * CYCLES_PER_US;
  localparam int SUSPEND_IDLE_CYCLES = SUSPEND_IDLE_US * CYCLES_PER_US;

  // Register byte offsets
  localparam logic [11:0] DEVICE_CONTROL_OFS = 12'h000;
  localparam logic [11:0] IRQ_FLAGS_OFS = 12'h004;
  localparam logic [11:0] IRQ_FLAG_CLEAR_OFS = 12'h008;
  localparam logic [11:0] IRQ_ENABLE_OFS = 12'h010;
  localparam logic [11:0] IRQ_ENABLE_CLEAR_OFS = 12'h014;
  localparam logic [11:0] IRQ_ENABLE_SET_OFS = 12'h018;
  localparam logic [11:0] ADDRESS_SPAN_OFS = 12'h820;
  localparam logic [11:0] NAME_ONE_OFS = 12'h824;
  localparam logic [11:0] NAME_TWO_OFS = 12'h828;
  localparam logic [11:0] DUAL_ROLE_STATE_OFS = 12'h82c;

  // Device control fields
  localparam int LOW_SPEED_BIT = 12;
  localparam int REMOTE_WAKE_BIT = 9;
  localparam int DETACH_BIT = 8;
  localparam int ADDRESS_ENABLE_BIT = 7;
  localparam int ADDRESS_WIDTH = 7;
  localparam logic [31:0] DEVICE_CONTROL_RESET = 32'h0000_0100;

  // Interrupt flag fields
  localparam int BUS_IDLE_BIT = 0;
  localparam int FRAME_START_BIT = 2;
  localparam int END_OF_BUS_RESET_BIT = 3;
  localparam int LINE_ACTIVITY_BIT = 4;
  localparam int END_OF_RESUME_BIT = 5;
  localparam int UPSTREAM_RESUME_BIT = 6;
  localparam int ENDPOINT_LSB = 12;
  localparam int ENDPOINT_COUNT = 7;
  localparam int DMA_LSB = 25;
  localparam int DMA_COUNT = 6;
  localparam logic [31:0] IRQ_FLAG_MASK = 32'h7e07_f07d;
  localparam logic [31:0] IRQ_FLAGS_RESET = 32'h0000_0000;
  localparam logic [31:0] IRQ_ENABLE_RESET = 32'h0000_0000;
  localparam int FRAME_NUMBER_WIDTH = 11;

  typedef enum logic [3:0] {
    A_IDLE = 4'h0,
    A_WAIT_VRISE = 4'h1,
    A_WAIT_BCON = 4'h2,
    A_HOST = 4'h3,
    A_SUSPEND = 4'h4,
    A_PERIPHERAL = 4'h5,
    A_WAIT_VFALL = 4'h6,
    A_VBUS_ERR = 4'h7,
    A_WAIT_DISCHARGE = 4'h8,
    B_IDLE = 4'h9,
    B_PERIPHERAL = 4'ha,
    B_WAIT_BEGIN_HNP = 4'hb,
    B_WAIT_DISCHARGE = 4'hc,
    B_WAIT_ACON = 4'hd,
    B_HOST = 4'he,
    B_SRP_INIT = 4'hf
  } udgc_drd_state_t;

  localparam udgc_drd_state_t DRD_STATE_RESET = B_IDLE;

endpackage

// ==== rtl/udgc_fsm_if.sv ====
`timescale 1ns/10ps
interface udgc_fsm_if;
  logic id_pin;
  logic vbus_valid;
  logic session_valid;
  logic vbus_overcurrent;
  logic vbus_request;
  logic srp_request;
  logic hnp_request;
  logic peer_connect;
  logic bus_suspended;
  logic [3:0] drd_state;

  modport ctrl (
    output id_pin, vbus_valid, session_valid, vbus_overcurrent, vbus_request,
    output srp_request, hnp_request, peer_connect, bus_suspended,
    input drd_state
  );
  modport fsm (
    input id_pin, vbus_valid, session_valid, vbus_overcurrent, vbus_request,
    input srp_request, hnp_request, peer_connect, bus_suspended,
    output drd_state
  );
endinterface

// ==== rtl/udgc_drd_fsm.sv ====
`timescale 1ns/10ps
module udgc_drd_fsm #(
  parameter int DISCHARGE_CYCLES = udgc_pkg::DISCHARGE_CYCLES,
  parameter int HNP_WAIT_CYCLES = udgc_pkg::HNP_WAIT_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  udgc_fsm_if.fsm bus
);

  udgc_pkg::udgc_drd_state_t state_reg;
  udgc_pkg::udgc_drd_state_t state_next;
  logic [31:0] timer_reg;
  logic discharge_done;
  logic hnp_wait_done;

  assign discharge_done = timer_reg >= 32'(DISCHARGE_CYCLES - 1);
  assign hnp_wait_done = timer_reg >= 32'(HNP_WAIT_CYCLES - 1);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= udgc_pkg::DRD_STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Dwell timer restarts on every state change
  always_ff @(posedge clk) begin
    if (!rstn) begin
      timer_reg <= 32'h0000_0000;
    end else if (state_next != state_reg) begin
      timer_reg <= 32'h0000_0000;
    end else if (timer_reg != 32'hffff_ffff) begin
      timer_reg <= timer_reg + 32'h0000_0001;
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      udgc_pkg::A_IDLE: begin
        if (bus.id_pin) state_next = udgc_pkg::B_IDLE;
        else if (bus.vbus_request) state_next = udgc_pkg::A_WAIT_VRISE;
      end
      udgc_pkg::A_WAIT_VRISE: begin
        if (bus.vbus_overcurrent) state_next = udgc_pkg::A_VBUS_ERR;
        else if (bus.vbus_valid) state_next = udgc_pkg::A_WAIT_BCON;
      end
      udgc_pkg::A_WAIT_BCON: begin
        if (bus.vbus_overcurrent) state_next = udgc_pkg::A_VBUS_ERR;
        else if (bus.peer_connect) state_next = udgc_pkg::A_HOST;
      end
      udgc_pkg::A_HOST: begin
        if (bus.vbus_overcurrent) state_next = udgc_pkg::A_VBUS_ERR;
        else if (bus.bus_suspended) state_next = udgc_pkg::A_SUSPEND;
      end
      udgc_pkg::A_SUSPEND: begin
        if (bus.vbus_overcurrent) state_next = udgc_pkg::A_VBUS_ERR;
        else if (!bus.peer_connect) state_next = udgc_pkg::A_PERIPHERAL;
        else if (!bus.bus_suspended) state_next = udgc_pkg::A_HOST;
      end
      udgc_pkg::A_PERIPHERAL: begin
        if (bus.vbus_overcurrent) state_next = udgc_pkg::A_VBUS_ERR;
        else if (bus.bus_suspended) state_next = udgc_pkg::A_WAIT_DISCHARGE;
      end
      udgc_pkg::A_WAIT_VFALL: begin
        if (!bus.session_valid) state_next = udgc_pkg::A_IDLE;
      end
      udgc_pkg::A_VBUS_ERR: begin
        if (!bus.vbus_overcurrent) state_next = udgc_pkg::A_WAIT_VFALL;
      end
      udgc_pkg::A_WAIT_DISCHARGE: begin
        if (discharge_done) state_next = udgc_pkg::A_WAIT_BCON; // [R03]
      end
      udgc_pkg::B_IDLE: begin
        if (!bus.id_pin) state_next = udgc_pkg::A_IDLE;
        else if (bus.session_valid) state_next = udgc_pkg::B_PERIPHERAL;
        else if (bus.srp_request) state_next = udgc_pkg::B_SRP_INIT;
      end
      udgc_pkg::B_PERIPHERAL: begin
        if (!bus.session_valid) state_next = udgc_pkg::B_IDLE;
        else if (bus.bus_suspended) state_next = udgc_pkg::B_WAIT_BEGIN_HNP;
      end
      udgc_pkg::B_WAIT_BEGIN_HNP: begin
        if (!bus.session_valid) state_next = udgc_pkg::B_IDLE;
        else if (!bus.bus_suspended) state_next = udgc_pkg::B_PERIPHERAL;
        else if (hnp_wait_done && bus.hnp_request) begin // [R04]
          state_next = udgc_pkg::B_WAIT_DISCHARGE;
        end
      end
      udgc_pkg::B_WAIT_DISCHARGE: begin
        if (discharge_done) state_next = udgc_pkg::B_WAIT_ACON; // [R03]
      end
      udgc_pkg::B_WAIT_ACON: begin
        if (!bus.session_valid) state_next = udgc_pkg::B_IDLE;
        else if (bus.peer_connect) state_next = udgc_pkg::B_HOST;
      end
      udgc_pkg::B_HOST: begin
        if (!bus.session_valid) state_next = udgc_pkg::B_IDLE;
        else if (!bus.peer_connect) state_next = udgc_pkg::B_PERIPHERAL;
      end
      udgc_pkg::B_SRP_INIT: begin
        if (bus.session_valid) state_next = udgc_pkg::B_PERIPHERAL;
        else if (!bus.srp_request) state_next = udgc_pkg::B_IDLE;
      end
    endcase
  end

  assign bus.drd_state = state_reg; // [R01] [R02]

endmodule

// ==== rtl/udgc_top.sv ====
// How it works
// R01: State field reports A-device states with codes 0 to 8.
// R02: State field reports B-device states with codes 9 to 15; reset is 9.
// R03: Discharge-wait states 8 and 12 hold 100 us; 12 moves toward host.
// R04: State 11 waits 3 ms and a negotiation request before moving on.
// R05: Low-speed bit 12 always writable; disable or freeze never resets it.
// R06: Remote wake bit 9 requests resume; clears when sent or on bus reset.
// R07: Detach bit 8 drops the pull-up; control resets to 0x100, detached.
// R08: Address-enable bit 7 set by writing one; cleared by bus reset.
// R09: Device address field holds bus address; cleared by bus reset.
// R10: DMA flags 25 to 30 follow their channel interrupt sources.
// R11: Endpoint flags 12 to 18 follow their endpoint interrupt sources.
// R12: Upstream resume flag 6 sets when resume sent; write-one clears.
// R13: End-of-resume flag 5 sets on host end of resume; write-one clears.
// R14: Line activity flag 4 sets on wake by line, even frozen; suspend clears.
// R15: Line activity flag also clears by write-one with clock running.
// R16: End-of-bus-reset flag 3 sets at reset end; write-one clears.
// R17: Frame flag 2 sets on each frame start, frame number updated too.
// R18: Suspend flag 0 sets after 3 ms idle; write-one or wake clears.
// R19: Read-only word reports the register address span size.
// R20: Two read-only words hold the controller name in ASCII.
// R21: Write-one clear register at 0x008; zeros ignored; reads zero.
// R22: Enable bits set and cleared through their own set and clear words.
// R23: Interrupt output high while any flag and its enable are both one.
`timescale 1ns/10ps
module udgc_top #(
  parameter int DISCHARGE_CYCLES = udgc_pkg::DISCHARGE_CYCLES,
  parameter int HNP_WAIT_CYCLES = udgc_pkg::HNP_WAIT_CYCLES,
  parameter int SUSPEND_IDLE_CYCLES = udgc_pkg::SUSPEND_IDLE_CYCLES,
  // Arbitrary identity and span values
  parameter logic [31:0] NAME_WORD_ONE = 32'h5553_4243,
  parameter logic [31:0] NAME_WORD_TWO = 32'h4f52_4530,
  parameter logic [31:0] ADDRESS_SPAN = 32'h0000_1000
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic controller_enable,
  input wire logic clock_freeze,
  input wire logic id_pin,
  input wire logic vbus_valid,
  input wire logic session_valid,
  input wire logic vbus_overcurrent,
  input wire logic vbus_request,
  input wire logic srp_request,
  input wire logic hnp_request,
  input wire logic peer_connect,
  input wire logic line_j_idle,
  input wire logic line_activity,
  input wire logic bus_reset,
  input wire logic frame_start,
  input wire logic [10:0] frame_number_in,
  input wire logic end_of_resume,
  input wire logic resume_sent,
  input wire logic [6:0] endpoint_irq,
  input wire logic [5:0] dma_channel_irq,
  output logic low_speed_force,
  output logic pullup_detach,
  output logic remote_wake_request,
  output logic address_enable,
  output logic [6:0] device_address,
  output logic [10:0] frame_number,
  output logic usb_irq
);

  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  udgc_fsm_if fsm_bus ();

  logic clock_live;
  logic ctrl_wr;
  logic flag_clr_wr;
  logic en_clr_wr;
  logic en_set_wr;
  logic [31:0] flag_clear;
  logic [31:0] flag_set;
  logic [31:0] flags_reg;
  logic [31:0] flags_next;
  logic [31:0] enable_reg;
  logic [31:0] enable_next;
  logic [31:0] control_word;
  logic [31:0] read_word;
  logic [31:0] rdata_reg;
  logic low_speed_reg;
  logic detach_reg;
  logic remote_wake_reg;
  logic remote_wake_next;
  logic address_enable_reg;
  logic address_enable_next;
  logic [6:0] address_reg;
  logic [10:0] frame_number_reg;
  logic bus_reset_q;
  logic end_of_bus_reset;
  logic [31:0] idle_count_reg;
  logic bus_suspended_reg;
  logic suspend_detect;
  logic wake_detect;

  // Bus-side flag events other than line wake need a running, enabled controller
  assign clock_live = controller_enable && !clock_freeze;

  assign ctrl_wr = reg_wr && reg_hit(reg_addr, udgc_pkg::DEVICE_CONTROL_OFS);
  assign flag_clr_wr = reg_wr && reg_hit(reg_addr, udgc_pkg::IRQ_FLAG_CLEAR_OFS);
  assign en_clr_wr = reg_wr && reg_hit(reg_addr, udgc_pkg::IRQ_ENABLE_CLEAR_OFS);
  assign en_set_wr = reg_wr && reg_hit(reg_addr, udgc_pkg::IRQ_ENABLE_SET_OFS);

  assign fsm_bus.id_pin = id_pin;
  assign fsm_bus.vbus_valid = vbus_valid;
  assign fsm_bus.session_valid = session_valid;
  assign fsm_bus.vbus_overcurrent = vbus_overcurrent;
  assign fsm_bus.vbus_request = vbus_request;
  assign fsm_bus.srp_request = srp_request;
  assign fsm_bus.hnp_request = hnp_request;
  assign fsm_bus.peer_connect = peer_connect;
  assign fsm_bus.bus_suspended = bus_suspended_reg;

  udgc_drd_fsm #(
    .DISCHARGE_CYCLES(DISCHARGE_CYCLES),
    .HNP_WAIT_CYCLES(HNP_WAIT_CYCLES)
  ) u_drd_fsm (
    .clk(clk),
    .rstn(rstn),
    .bus(fsm_bus)
  );

  // Low-speed select ignores enable and freeze on purpose
  always_ff @(posedge clk) begin
    if (!rstn) begin
      low_speed_reg <= udgc_pkg::DEVICE_CONTROL_RESET[udgc_pkg::LOW_SPEED_BIT];
    end else if (ctrl_wr) begin
      low_speed_reg <= reg_wdata[udgc_pkg::LOW_SPEED_BIT]; // [R05]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      detach_reg <= udgc_pkg::DEVICE_CONTROL_RESET[udgc_pkg::DETACH_BIT]; // [R07]
    end else if (ctrl_wr && clock_live) begin
      detach_reg <= reg_wdata[udgc_pkg::DETACH_BIT]; // [R07]
    end
  end

  // Write of one wins over a same-cycle clear
  always_comb begin
    remote_wake_next = remote_wake_reg;
    if (bus_reset || resume_sent) begin
      remote_wake_next = 1'b0; // [R06]
    end
    if (ctrl_wr && clock_live && reg_wdata[udgc_pkg::REMOTE_WAKE_BIT]) begin
      remote_wake_next = 1'b1; // [R06]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      remote_wake_reg <= udgc_pkg::DEVICE_CONTROL_RESET[udgc_pkg::REMOTE_WAKE_BIT];
    end else begin
      remote_wake_reg <= remote_wake_next;
    end
  end

  always_comb begin
    address_enable_next = address_enable_reg;
    if (bus_reset) begin
      address_enable_next = 1'b0; // [R08]
    end
    if (ctrl_wr && clock_live && reg_wdata[udgc_pkg::ADDRESS_ENABLE_BIT]) begin
      address_enable_next = 1'b1; // [R08]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      address_enable_reg <= udgc_pkg::DEVICE_CONTROL_RESET[udgc_pkg::ADDRESS_ENABLE_BIT];
    end else begin
      address_enable_reg <= address_enable_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      address_reg <= udgc_pkg::DEVICE_CONTROL_RESET[udgc_pkg::ADDRESS_WIDTH-1:0];
    end else if (ctrl_wr && clock_live) begin
      address_reg <= reg_wdata[udgc_pkg::ADDRESS_WIDTH-1:0]; // [R09]
    end else if (bus_reset) begin
      address_reg <= 7'h00; // [R09]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      bus_reset_q <= 1'b0;
    end else begin
      bus_reset_q <= bus_reset;
    end
  end

  assign end_of_bus_reset = bus_reset_q && !bus_reset && clock_live;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      frame_number_reg <= 11'h000;
    end else if (frame_start && clock_live) begin
      frame_number_reg <= frame_number_in; // [R17]
    end
  end

  // Idle counter saturates so one idle period gives one suspend event
  always_ff @(posedge clk) begin
    if (!rstn) begin
      idle_count_reg <= 32'h0000_0000;
    end else if (!line_j_idle || !clock_live) begin
      idle_count_reg <= 32'h0000_0000;
    end else if (idle_count_reg != 32'(SUSPEND_IDLE_CYCLES)) begin
      idle_count_reg <= idle_count_reg + 32'h0000_0001;
    end
  end

  assign suspend_detect = clock_live && line_j_idle &&
                          (idle_count_reg == 32'(SUSPEND_IDLE_CYCLES - 1)); // [R18]

  // Line wake is accepted while frozen; only a suspended bus can wake
  assign wake_detect = controller_enable && line_activity && bus_suspended_reg; // [R14]

  always_ff @(posedge clk) begin
    if (!rstn) begin
      bus_suspended_reg <= 1'b0;
    end else if (suspend_detect) begin
      bus_suspended_reg <= 1'b1;
    end else if (line_activity || bus_reset || !controller_enable) begin
      bus_suspended_reg <= 1'b0;
    end
  end

  always_comb begin
    flag_set = 32'h0000_0000;
    flag_set[udgc_pkg::BUS_IDLE_BIT] = suspend_detect; // [R18]
    flag_set[udgc_pkg::FRAME_START_BIT] = frame_start && clock_live; // [R17]
    flag_set[udgc_pkg::END_OF_BUS_RESET_BIT] = end_of_bus_reset; // [R16]
    flag_set[udgc_pkg::LINE_ACTIVITY_BIT] = wake_detect; // [R14]
    flag_set[udgc_pkg::END_OF_RESUME_BIT] = end_of_resume && clock_live; // [R13]
    flag_set[udgc_pkg::UPSTREAM_RESUME_BIT] = resume_sent && clock_live; // [R12]
  end

  // Write-one clears; the upstream resume and line activity flags ignore it while frozen
  always_comb begin
    flag_clear = 32'h0000_0000;
    if (flag_clr_wr) begin
      flag_clear = reg_wdata & udgc_pkg::IRQ_FLAG_MASK; // [R21]
      flag_clear[udgc_pkg::ENDPOINT_LSB +: udgc_pkg::ENDPOINT_COUNT] = 7'h00;
      flag_clear[udgc_pkg::DMA_LSB +: udgc_pkg::DMA_COUNT] = 6'h00;
      if (clock_freeze) begin
        flag_clear[udgc_pkg::UPSTREAM_RESUME_BIT] = 1'b0; // [R12]
        flag_clear[udgc_pkg::LINE_ACTIVITY_BIT] = 1'b0; // [R15]
      end
    end
    if (suspend_detect) begin
      flag_clear[udgc_pkg::LINE_ACTIVITY_BIT] = 1'b1; // [R14]
    end
    if (wake_detect) begin
      flag_clear[udgc_pkg::BUS_IDLE_BIT] = 1'b1; // [R18]
    end
  end

  always_comb begin
    flags_next = ((flags_reg & ~flag_clear) | flag_set) & udgc_pkg::IRQ_FLAG_MASK;
    flags_next[udgc_pkg::ENDPOINT_LSB +: udgc_pkg::ENDPOINT_COUNT] = endpoint_irq; // [R11]
    flags_next[udgc_pkg::DMA_LSB +: udgc_pkg::DMA_COUNT] = dma_channel_irq; // [R10]
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      flags_reg <= udgc_pkg::IRQ_FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  always_comb begin
    enable_next = enable_reg;
    if (en_clr_wr) begin
      enable_next = enable_reg & ~reg_wdata; // [R22]
    end
    if (en_set_wr) begin
      enable_next = enable_reg | reg_wdata; // [R22]
    end
    enable_next = enable_next & udgc_pkg::IRQ_FLAG_MASK;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      enable_reg <= udgc_pkg::IRQ_ENABLE_RESET;
    end else begin
      enable_reg <= enable_next;
    end
  end

  always_comb begin
    control_word = 32'h0000_0000;
    control_word[udgc_pkg::LOW_SPEED_BIT] = low_speed_reg;
    control_word[udgc_pkg::REMOTE_WAKE_BIT] = remote_wake_reg;
    control_word[udgc_pkg::DETACH_BIT] = detach_reg;
    control_word[udgc_pkg::ADDRESS_ENABLE_BIT] = address_enable_reg;
    control_word[udgc_pkg::ADDRESS_WIDTH-1:0] = address_reg;
  end

  // Write-only words and unmapped offsets read as zero
  always_comb begin
    read_word = 32'h0000_0000;
    if (reg_hit(reg_addr, udgc_pkg::DEVICE_CONTROL_OFS)) begin
      read_word = control_word;
    end else if (reg_hit(reg_addr, udgc_pkg::IRQ_FLAGS_OFS)) begin
      read_word = flags_reg;
    end else if (reg_hit(reg_addr, udgc_pkg::IRQ_ENABLE_OFS)) begin
      read_word = enable_reg;
    end else if (reg_hit(reg_addr, udgc_pkg::ADDRESS_SPAN_OFS)) begin
      read_word = ADDRESS_SPAN; // [R19]
    end else if (reg_hit(reg_addr, udgc_pkg::NAME_ONE_OFS)) begin
      read_word = NAME_WORD_ONE; // [R20]
    end else if (reg_hit(reg_addr, udgc_pkg::NAME_TWO_OFS)) begin
      read_word = NAME_WORD_TWO; // [R20]
    end else if (reg_hit(reg_addr, udgc_pkg::DUAL_ROLE_STATE_OFS)) begin
      read_word = {28'h0000000, fsm_bus.drd_state}; // [R01] [R02]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_reg <= read_word;
    end
  end

  assign reg_rdata = rdata_reg;
  assign low_speed_force = low_speed_reg;
  assign pullup_detach = detach_reg;
  assign remote_wake_request = remote_wake_reg;
  assign address_enable = address_enable_reg;
  assign device_address = address_reg;
  assign frame_number = frame_number_reg;
  assign usb_irq = |(flags_reg & enable_reg); // [R23]

endmodule

// ==== test/udgc_top_chk.sv ====
`timescale 1ns/10ps
module udgc_top_chk (
  input logic clk,
  input logic rstn,
  input logic reg_wr,
  input logic reg_rd,
  input logic [11:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic [31:0] reg_rdata,
  input logic controller_enable,
  input logic clock_freeze,
  input logic bus_reset,
  input logic frame_start,
  input logic [10:0] frame_number_in,
  input logic low_speed_force,
  input logic pullup_detach,
  input logic address_enable,
  input logic [6:0] device_address,
  input logic [10:0] frame_number,
  input logic usb_irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_ctrl_wr;
    reg_wr && reg_addr == 12'h000 && controller_enable && !clock_freeze;
  endsequence
  // Writes win over a same-edge bus reset, so exclude them
  sequence s_live_idle;
    controller_enable && !clock_freeze && !reg_wr;
  endsequence
  AST_LS_WRITE: assert property (
    reg_wr && reg_addr == 12'h000 |=> low_speed_force == $past(reg_wdata[12]))
    else $error("speed bit missed a control write");
  AST_LS_HOLD: assert property (
    !(reg_wr && reg_addr == 12'h000) |=> $stable(low_speed_force))
    else $error("speed bit changed without a write");
  AST_DETACH: assert property (
    s_ctrl_wr |=> pullup_detach == $past(reg_wdata[8]))
    else $error("detach output does not follow write");
  AST_ADDR_EN: assert property (
    s_ctrl_wr ##0 reg_wdata[7] |=> address_enable)
    else $error("address enable not set by write");
  AST_BUS_RESET: assert property (
    s_live_idle ##0 bus_reset |=> !address_enable && device_address == 7'h00)
    else $error("address not cleared by bus reset");
  AST_FRAME: assert property (
    frame_start && controller_enable && !clock_freeze |=>
      frame_number == $past(frame_number_in))
    else $error("frame number not loaded");
  AST_CLR_READ: assert property (
    reg_rd && reg_addr == 12'h008 |=> reg_rdata == 32'h0000_0000)
    else $error("clear word read nonzero");
  AST_IRQ_OFF: assert property (
    reg_wr && reg_addr == 12'h014 && reg_wdata == 32'hffff_ffff |=> !usb_irq)
    else $error("interrupt with all enables cleared");
endmodule

// ==== test/udgc_host_model.sv ====
`timescale 1ns/10ps
module udgc_host_model (
  input wire logic clk,
  output logic line_j_idle,
  output logic line_activity,
  output logic bus_reset,
  output logic frame_start,
  output logic [10:0] frame_number_in,
  output logic end_of_resume,
  output logic resume_sent
);
  logic [4:0] lv = 5'h00;
  assign {resume_sent, end_of_resume, bus_reset, line_activity, line_j_idle} = lv;
  initial frame_start = 1'b0;
  initial frame_number_in = 11'h000;
  task automatic frame(input logic [10:0] fn);
    @(negedge clk);
    frame_start = 1'b1;
    frame_number_in = fn;
    @(negedge clk);
    frame_start = 1'b0;
    // Scrambled outside the strobe so a stale sample cannot pass
    frame_number_in = ~fn;
  endtask
  // Holds one line high for n edges, then lets the flag settle
  task automatic level(input int b, input int n);
    @(negedge clk);
    lv[b] = 1'b1;
    repeat (n) @(negedge clk);
    lv[b] = 1'b0;
    repeat (2) @(negedge clk);
  endtask
endmodule

// ==== test/udgc_top_test.sv ====
`timescale 1ns/10ps
module udgc_top_test;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic controller_enable = 1'b0;
  logic clock_freeze = 1'b0;
  logic [7:0] otg = 8'h01;
  logic [6:0] endpoint_irq = 7'h00;
  logic [5:0] dma_channel_irq = 6'h00;
  logic [31:0] reg_rdata, src;
  logic line_j_idle, line_activity, bus_reset, frame_start, end_of_resume, resume_sent;
  logic low_speed_force, pullup_detach, remote_wake_request, address_enable, usb_irq;
  logic [10:0] frame_number_in, frame_number;
  logic [6:0] device_address;
  logic [31:0] exp_q[$];
  int bad_count = 0;
  int checks_done = 0;
  int seed = 11687;
  // Arbitrary identity and span values
  localparam logic [31:0] NAME_ONE = 32'h7465_7374;
  localparam logic [31:0] NAME_TWO = 32'h6465_7631;
  localparam logic [31:0] SPAN = 32'h0000_0900;
  always #10 clk = ~clk;
  udgc_top #(.DISCHARGE_CYCLES(20), .HNP_WAIT_CYCLES(40), .SUSPEND_IDLE_CYCLES(40),
    .NAME_WORD_ONE(NAME_ONE), .NAME_WORD_TWO(NAME_TWO), .ADDRESS_SPAN(SPAN)) i_udgc_top (
    .clk, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .controller_enable,
    .clock_freeze, .id_pin(otg[0]), .vbus_valid(otg[1]), .session_valid(otg[2]),
    .vbus_overcurrent(otg[3]), .vbus_request(otg[4]), .srp_request(otg[5]),
    .hnp_request(otg[6]), .peer_connect(otg[7]), .line_j_idle, .line_activity, .bus_reset,
    .frame_start, .frame_number_in, .end_of_resume, .resume_sent, .endpoint_irq,
    .dma_channel_irq, .low_speed_force, .pullup_detach, .remote_wake_request,
    .address_enable, .device_address, .frame_number, .usb_irq);
  udgc_host_model i_udgc_host_model (.clk, .line_j_idle, .line_activity, .bus_reset,
    .frame_start, .frame_number_in, .end_of_resume, .resume_sent);
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    exp_q.push_back(e);
    @(negedge clk);
    reg_rd = 1'b0;
  endtask
  // Read data lands on the strobe edge; checked at the next falling edge
  always @(posedge clk) begin
    if (reg_rd === 1'b1) begin
      @(negedge clk);
      chk("reg_rdata", reg_rdata, exp_q.pop_front());
    end
  end
  task automatic results;
    if (exp_q.size() > 0) bad_count++;
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end
  initial begin
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    rd(12'h000, 32'h100);
    rd(12'h82c, 32'h9);
    rd(12'h824, NAME_ONE);
    rd(12'h828, NAME_TWO);
    rd(12'h820, SPAN);
    rd(12'h008, 32'h0);
    rd(12'h100, 32'h0);
    $display("test reset done");
    wr(12'h000, 32'h1285);
    rd(12'h000, 32'h1100);
    controller_enable = 1'b1;
    wr(12'h000, 32'h285);
    wr(12'h000, 32'h5);
    rd(12'h000, 32'h285);
    i_udgc_host_model.level(4, 1);
    chk("remote_wake_request", {31'h0, remote_wake_request}, 32'h0);
    i_udgc_host_model.level(2, 4);
    chk("device_address", {25'h0, device_address}, 32'h0);
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h48);
    wr(12'h008, 32'h48);
    rd(12'h004, 32'h0);
    $display("test control done");
    wr(12'h018, 32'h4);
    rd(12'h010, 32'h4);
    repeat (3) begin
      src = $random(seed);
      i_udgc_host_model.frame(src[10:0]);
      chk("frame_number", {21'h0, frame_number}, {21'h0, src[10:0]});
      wr(12'h008, 32'h0);
      chk("usb_irq", {31'h0, usb_irq}, 32'h1);
      wr(12'h008, 32'h4);
      chk("usb_irq", {31'h0, usb_irq}, 32'h0);
    end
    i_udgc_host_model.frame(11'h7ff);
    wr(12'h014, 32'hffff_ffff);
    chk("usb_irq", {31'h0, usb_irq}, 32'h0);
    rd(12'h004, 32'h4);
    wr(12'h008, 32'h4);
    $display("test frame done");
    // Session up with a negotiation request, so suspend walks states 10 to 13
    otg = 8'h45;
    // One idle edge short of the limit must not suspend
    i_udgc_host_model.level(0, 39);
    rd(12'h004, 32'h0);
    i_udgc_host_model.level(0, 40);
    rd(12'h004, 32'h1);
    rd(12'h82c, 32'hb);
    repeat (40) @(negedge clk);
    rd(12'h82c, 32'hc);
    repeat (20) @(negedge clk);
    rd(12'h82c, 32'hd);
    i_udgc_host_model.level(1, 1);
    rd(12'h004, 32'h10);
    i_udgc_host_model.level(0, 40);
    rd(12'h004, 32'h1);
    clock_freeze = 1'b1;
    i_udgc_host_model.level(1, 1);
    wr(12'h000, 32'h1000);
    wr(12'h008, 32'h11);
    rd(12'h004, 32'h10);
    clock_freeze = 1'b0;
    wr(12'h008, 32'h10);
    rd(12'h004, 32'h0);
    i_udgc_host_model.level(3, 1);
    rd(12'h004, 32'h20);
    wr(12'h008, 32'h20);
    $display("test suspend done");
    wr(12'h018, 32'h7e07_f07d);
    repeat (4) begin
      src = $random(seed);
      @(negedge clk);
      endpoint_irq = src[6:0];
      dma_channel_irq = src[12:7];
      wr(12'h008, 32'h7e07_f000);
      rd(12'h004, {1'b0, src[12:7], 6'h0, src[6:0], 12'h0});
      chk("usb_irq", {31'h0, usb_irq}, {31'h0, |src[12:0]});
    end
    wr(12'h014, 32'hffff_ffff);
    $display("test flags done");
    results();
  end
endmodule
bind udgc_top udgc_top_chk i_udgc_top_chk (.clk, .rstn, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .controller_enable, .clock_freeze, .bus_reset, .frame_start,
  .frame_number_in, .low_speed_force, .pullup_detach, .address_enable, .device_address,
  .frame_number, .usb_irq);
